// [four_bit_controller_core.sv]
// four-bit controller core: sequencer, decoder, datapath and ports
`timescale 1ns/1ns
`default_nettype none
`include "core_cfg.svh"
module four_bit_controller_core
  import core_pkg::*;
(
  input  wire logic        clk,                // 100 MHz
  input  wire logic        sys_rst,            // sync, active high
  input  wire logic        ce,                 // freezes all state when low
  input  wire logic        rom_we,             // program load strobe
  input  wire logic [10:0] rom_waddr,          // program load address
  input  wire logic [9:0]  rom_wdata,          // program load word
  input  wire logic [3:0]  key_in,             // 4-bit input port
  input  wire logic        test_input_bit,     // testable input
  input  wire logic        high_priority_irq,  // interrupt line A
  input  wire logic        low_priority_line,  // interrupt line B
  input  wire logic [3:0]  s_in,               // two-way port, pin level
  output logic      [3:0]  s_out,              // two-way port drive value
  output logic             s_oe,               // two-way port enable
  output logic      [7:0]  strobe_out,         // strobe port
  output logic      [7:0]  seg_out,            // immediate output port
  output logic      [9:0]  f_out               // discrete lines
);
  // ---------------------------------------------------------------
  // storage, state and pin synchronisers
  // ---------------------------------------------------------------
  logic [9:0]  rom [0:`ROM_WORDS-1];
  logic [3:0]  ram [0:`RAM_WORDS-1];
  logic [10:0] stack [0:3];
  seq_state_type state;
  logic [9:0]  cnt;
  logic [10:0] pc;
  logic [1:0]  sp;
  logic [3:0]  acc, tr, col;
  logic [2:0]  row;
  logic        carry, daf, decimal_sub_flag, skip, en_a, en_b;
  logic [7:0]  q;
  logic [10:0] sync1, sync2;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
    end else if (ce) begin
      sync1 <= {s_in, key_in, test_input_bit, high_priority_irq, low_priority_line};
      sync2 <= sync1;
    end
  end
  logic [3:0] key_s, s_s;
  logic       test_s, irq_a_s, irq_b_s;
  // bits pass singly; a nibble in motion may tear for one sample
  assign s_s     = sync2[10:7];
  assign key_s   = sync2[6:3];
  assign test_s  = sync2[2];
  assign irq_a_s = sync2[1];
  assign irq_b_s = sync2[0];
  // ---------------------------------------------------------------
  // instruction cycle sequencer, fetch and interrupt arbitration
  // ---------------------------------------------------------------
  // fixed cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_COUNT;
      cnt   <= 10'h000;
    end else if (ce) begin
      case (state)
        ST_COUNT: begin
          cnt <= 10'(cnt + 10'h001);
          if (cnt == 10'(`INSN_CLKS - 2)) state <= ST_EXEC;
        end
        ST_EXEC: begin
          cnt   <= 10'h000;
          state <= ST_COUNT;
        end
        default: state <= ST_COUNT;
      endcase
    end
  end
  logic [9:0]  insn;
  logic [10:0] pc_seq;
  logic        exec, take_a, take_b, take_irq, run;
  assign insn   = (pc[10:7] != `BAD_PAGE) ? rom[pc] : `NOP_WORD;
  assign pc_seq = {pc[10:7], pc[5:0], ~(pc[6] ^ pc[5])};
  assign exec   = ce && state == ST_EXEC;
  assign take_a   = irq_a_s && en_a && !skip;
  assign take_b   = irq_b_s && en_b && !skip && !take_a;
  assign take_irq = take_a || take_b;
  assign run      = exec && !skip && !take_irq;
  always_ff @(posedge clk) begin
    if (ce && rom_we && rom_waddr[10:7] != `BAD_PAGE) rom[rom_waddr] <= rom_wdata;
  end
  // ---------------------------------------------------------------
  // decode and datapath
  // ---------------------------------------------------------------
  function automatic logic [4:0] alu_add(input logic [3:0] a, input logic [3:0] b,
                                         input logic ci, input logic dadd, input logic dsub);
    logic [4:0] s;
    s = 5'({1'b0, a} + {1'b0, b} + {4'h0, ci});
    if (dadd && s > `DEC_MAX) alu_add = {1'b1, 4'(s[3:0] + `DEC_ADJ)};
    else if (dsub && !s[4]) alu_add = {1'b0, 4'(s[3:0] + `DEC_SUB_ADJ)};
    else alu_add = s;
  endfunction
  logic       ram_ok, ram_we, push, pop;
  logic [6:0] ram_idx;
  logic [3:0] mem_rd, col_inc, col_dec, sub;
  logic       skip_inc, skip_dec;
  logic [10:0] next_pc;
  logic [3:0] next_acc, next_tr, next_col, next_s_out;
  logic [2:0] next_row;
  logic       next_c, next_daf, next_dsf, next_skip, next_en_a, next_en_b, next_s_oe;
  logic [7:0] next_q, next_strobe, next_seg;
  logic [9:0] next_f;
  assign ram_idx  = {row, col};
  assign ram_ok   = row < `RAM_ROWS;
  assign mem_rd   = ram_ok ? ram[ram_idx] : 4'h0;
  assign col_inc  = 4'(col + 4'h1);
  assign col_dec  = 4'(col - 4'h1);
  assign skip_inc = col_inc == `COL_INC_SKIP_A || col_inc == `COL_INC_SKIP_B;
  assign skip_dec = col_dec == `COL_DEC_SKIP_A || col_dec == `COL_DEC_SKIP_B;
  assign sub      = insn[3:0];
  always_comb begin
    next_pc = pc_seq; push = 1'b0; pop = 1'b0; ram_we = 1'b0;
    next_acc = acc; next_tr = tr; next_col = col; next_row = row; next_c = carry;
    next_daf = daf; next_dsf = decimal_sub_flag; next_skip = 1'b0; next_en_a = en_a;
    next_en_b = en_b; next_q = q; next_strobe = strobe_out; next_seg = seg_out;
    next_f = f_out; next_s_out = s_out; next_s_oe = s_oe;
    case (insn[9:8])
      `MAJ_LOW: begin
        case (insn[9:4])
          `GRP_MISC_A: begin
            case (sub)
              `A_CMA: next_acc = ~acc;
              `A_CIA: next_acc = 4'(~acc + 4'h1);
              `A_INA: {next_skip, next_acc} = 5'({1'b0, acc} + 5'h01);
              `A_DEA: {next_skip, next_acc} = {acc != 4'h0, 4'(acc - 4'h1)};
              `A_RFC: next_c = 1'b0;
              `A_SFC: next_c = 1'b1;
              `A_DSM: next_dsf = 1'b1;
              `A_DAM: next_daf = 1'b1;
              `A_BIN: {next_daf, next_dsf} = 2'h0;
              `A_AD: {next_skip, next_acc} = alu_add(acc, mem_rd, 1'b0, daf, decimal_sub_flag);
              `A_ADC: {next_c, next_acc} = alu_add(acc, mem_rd, carry, daf, decimal_sub_flag);
              `A_IND: {next_skip, next_col} = {skip_inc, col_inc};
              `A_DED: {next_skip, next_col} = {skip_dec, col_dec};
              `A_RT, `A_RTS: begin
                pop = 1'b1;
                next_pc = stack[2'(sp - 2'h1)];
                next_skip = sub == `A_RTS;
              end
              default: next_acc = acc;
            endcase
          end
          `GRP_MISC_B: begin
            case (sub)
              `B_EIA: next_en_a = 1'b1;
              `B_DIA: next_en_a = 1'b0;
              `B_EIB: next_en_b = 1'b1;
              `B_DIB: next_en_b = 1'b0;
              `B_QS1: next_q = {q[6:0], 1'b1};
              `B_QS0: next_q = {q[6:0], 1'b0};
              `B_OQR: next_strobe = q;
              `B_OTR: next_strobe = {tr, col};
              `B_SFS: {next_s_out, next_s_oe} = {acc, 1'b1};
              `B_RFS: next_s_oe = 1'b0;
              `B_IS: next_acc = s_s;
              `B_IK: next_acc = key_s;
              `B_SK4: next_skip = test_s;
              `B_XTA: {next_acc, next_tr} = {tr, acc};
              `B_SC: next_skip = carry;
              `B_SEM: next_skip = acc == mem_rd;
              default: next_acc = acc;
            endcase
          end
          `GRP_ADI: {next_skip, next_acc} = alu_add(acc, sub, 1'b0, daf, decimal_sub_flag);
          `GRP_LI: next_acc = sub;
          `GRP_LTI: next_tr = sub;
          `GRP_SEI: next_skip = acc == sub;
          `GRP_LM, `GRP_XM, `GRP_XMI, `GRP_XMD: begin
            next_acc = mem_rd;
            next_row = row ^ insn[2:0];
            ram_we = insn[9:4] != `GRP_LM;
            if (insn[9:4] == `GRP_XMI) {next_skip, next_col} = {skip_inc, col_inc};
            if (insn[9:4] == `GRP_XMD) {next_skip, next_col} = {skip_dec, col_dec};
          end
          `GRP_SF: if (sub < `F_LINES) next_f[sub] = 1'b1;
          `GRP_RF: if (sub < `F_LINES) next_f[sub] = 1'b0;
          default: next_acc = acc;
        endcase
      end
      `MAJ_LDI_JPT: begin
        if (insn[7]) next_pc = {tr, insn[6:0]};
        else {next_row, next_col} = insn[6:0];
      end
      `MAJ_JUMP: begin
        push = insn[7];
        next_pc = insn[7] ? {`CAL_PAGE, insn[6:0]} : {pc[10:7], insn[6:0]};
      end
      default: next_seg = insn[7:0];
    endcase
  end
  // ---------------------------------------------------------------
  // program counter, stack, interrupt enables and skip
  // ---------------------------------------------------------------
  // page over counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc <= 11'h000;
      sp <= 2'h0;
    end else if (exec) begin
      if (take_irq) begin
        pc <= take_a ? `VEC_A : `VEC_B;
        sp <= 2'(sp + 2'h1);
      end else if (run) begin
        pc <= next_pc;
        if (push) sp <= 2'(sp + 2'h1);
        else if (pop) sp <= 2'(sp - 2'h1);
      end else begin
        pc <= pc_seq;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!sys_rst && exec && (take_irq || (run && push))) stack[sp] <= take_irq ? pc : pc_seq;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_a <= 1'b0;
      en_b <= 1'b0;
      skip <= 1'b0;
    end else if (exec) begin
      skip <= run && next_skip;
      if (take_a) begin
        en_a <= 1'b0;
        en_b <= 1'b0;
      end else if (take_b) begin
        en_b <= 1'b0;
      end else if (run) begin
        en_a <= next_en_a;
        en_b <= next_en_b;
      end
    end
  end
  // ---------------------------------------------------------------
  // datapath registers, ram and ports
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc <= 4'h0; tr <= 4'h0; col <= 4'h0; row <= 3'h0; carry <= 1'b0;
      daf <= 1'b0; decimal_sub_flag <= 1'b0; q <= 8'h00;
      strobe_out <= 8'h00; seg_out <= 8'h00; f_out <= 10'h000;
      s_out <= 4'h0; s_oe <= 1'b0;
    end else if (run) begin
      acc <= next_acc; tr <= next_tr; col <= next_col; row <= next_row;
      carry <= next_c; daf <= next_daf; decimal_sub_flag <= next_dsf; q <= next_q;
      strobe_out <= next_strobe; seg_out <= next_seg; f_out <= next_f;
      s_out <= next_s_out; s_oe <= next_s_oe;
    end
  end
  always_ff @(posedge clk) begin
    if (!sys_rst && run && ram_we && ram_ok) ram[ram_idx] <= acc;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic is_a;
  assign is_a = insn[9:4] == `GRP_MISC_A;
  property p_page_hold;
    run && insn[9:8] == `MAJ_LOW && !(is_a && (sub == `A_RT || sub == `A_RTS))
      |=> pc[10:7] == $past(pc[10:7]);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page moved");
  property p_irq_a;
    exec && take_a |=> !en_a && !en_b && pc == `VEC_A;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("line A accept wrong");
  property p_irq_b;
    exec && take_b |=> !en_b && en_a == $past(en_a) && pc == `VEC_B;
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("line B accept wrong");
  property p_push;
    exec && take_irq |=> sp == 2'($past(sp) + 2'h1) && stack[$past(sp)] == $past(pc);
  endproperty
  a_push: assert property (p_push) else $error("stack push wrong");
  property p_row_xor;
    run && insn[9:4] == `GRP_LM |=> row == ($past(row) ^ $past(insn[2:0]));
  endproperty
  a_row_xor: assert property (p_row_xor) else $error("row xor wrong");
  property p_ind_skip;
    run && is_a && sub == `A_IND |=> skip == (col == `COL_INC_SKIP_A || col == `COL_INC_SKIP_B);
  endproperty
  a_ind_skip: assert property (p_ind_skip) else $error("increment skip wrong");
  property p_skip_void;
    exec && skip |=> !skip && acc == $past(acc) && pc == $past(pc_seq);
  endproperty
  a_skip_void: assert property (p_skip_void) else $error("skipped word acted");
  property p_cma;
    run && is_a && sub == `A_CMA |=> acc == ~$past(acc);
  endproperty
  a_cma: assert property (p_cma) else $error("complement wrong");
  property p_shift;
    run && insn[9:4] == `GRP_MISC_B && sub == `B_QS1 |=> q[7:1] == $past(q[6:0]) && q[0];
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");
  property p_gap;
    exec |=> !exec;
  endproperty
  a_gap: assert property (p_gap) else $error("cycle too short");
  c_irq_a: cover property (exec && take_a && irq_b_s && en_b);
  c_irq_b: cover property (exec && take_b);
  c_skip:  cover property (exec && skip);
  c_call:  cover property (run && push);
endmodule
`default_nettype wire

// [core_cfg.svh]
// timing, opcode and address constants for the four-bit controller core
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH
`define CLK_PERIOD_NS 10
`define INSN_CYCLE_NS 10000
`define INSN_CLKS (`INSN_CYCLE_NS / `CLK_PERIOD_NS)
`define ROM_WORDS 1920
`define RAM_WORDS 96
`define RAM_ROWS 3'h6
`define BAD_PAGE 4'hF
`define CAL_PAGE 4'h8
`define VEC_A 11'h010
`define VEC_B 11'h020
`define NOP_WORD 10'h0F0
`define F_LINES 4'hA
`define DEC_MAX 5'h09
`define DEC_ADJ 4'h6
`define DEC_SUB_ADJ 4'hA
`define COL_INC_SKIP_A 4'h8
`define COL_INC_SKIP_B 4'h0
`define COL_DEC_SKIP_A 4'hF
`define COL_DEC_SKIP_B 4'h7
// major field insn[9:8]
`define MAJ_LOW 2'h0
`define MAJ_LDI_JPT 2'h1
`define MAJ_JUMP 2'h2
`define MAJ_OIU 2'h3
// group field insn[9:4] under MAJ_LOW
`define GRP_MISC_A 6'h00
`define GRP_MISC_B 6'h01
`define GRP_ADI 6'h02
`define GRP_LI 6'h03
`define GRP_LM 6'h04
`define GRP_XM 6'h05
`define GRP_XMI 6'h06
`define GRP_XMD 6'h07
`define GRP_SF 6'h08
`define GRP_RF 6'h09
`define GRP_SEI 6'h0A
`define GRP_LTI 6'h0B
// misc group A, insn[3:0]
`define A_CMA 4'h0
`define A_CIA 4'h1
`define A_INA 4'h2
`define A_DEA 4'h3
`define A_RFC 4'h4
`define A_SFC 4'h5
`define A_DSM 4'h6
`define A_DAM 4'h7
`define A_AD 4'h8
`define A_ADC 4'h9
`define A_IND 4'hA
`define A_DED 4'hB
`define A_RT 4'hC
`define A_RTS 4'hD
`define A_BIN 4'hE
// misc group B, insn[3:0]
`define B_EIA 4'h0
`define B_DIA 4'h1
`define B_EIB 4'h2
`define B_DIB 4'h3
`define B_QS1 4'h4
`define B_QS0 4'h5
`define B_OQR 4'h6
`define B_OTR 4'h7
`define B_SFS 4'h8
`define B_RFS 4'h9
`define B_IS 4'hA
`define B_IK 4'hB
`define B_XTA 4'hC
`define B_SK4 4'hD
`define B_SC 4'hE
`define B_SEM 4'hF
`endif

// [core_pkg.sv]
// types shared by the four-bit controller core
`default_nettype none
package core_pkg;
  typedef enum logic [1:0] {
    ST_COUNT = 2'b01,
    ST_EXEC  = 2'b10
  } seq_state_type;
endpackage
`default_nettype wire

// [key_ram_partner.sv]
// keyboard, test switch and external ram nibble bus beside the core
`timescale 1ns/1ns
`default_nettype none
module key_ram_partner (
  input  wire logic [3:0] s_out,          // core drive value
  input  wire logic       s_oe,           // core drives the two-way port
  input  wire logic [3:0] key_val,        // pressed key pattern
  input  wire logic       test_val,       // test switch level
  input  wire logic [3:0] ram_nib,        // external ram read data
  output logic      [3:0] key_in,         // key port pins
  output logic            test_input_bit, // test pin
  output logic      [3:0] s_in            // two-way port pin level
);
  assign key_in         = key_val;
  assign test_input_bit = test_val;
  // ---------------------------------------------------------------
  // wire level of the shared port
  // ---------------------------------------------------------------
  // core or ram drives
  assign s_in = s_oe ? s_out : ram_nib;
endmodule
`default_nettype wire

// [four_bit_controller_core_tb.sv]
// self-checking bench running a small program through the core
`timescale 1ns/1ns
`default_nettype none
module four_bit_controller_core_tb;
  import core_pkg::*;
  logic        clk, sys_rst, ce, rom_we, hpi, lpl, tv;
  logic [10:0] rom_waddr;
  logic [9:0]  rom_wdata, f_out, e_f;
  logic [3:0]  key_in, s_in, s_out, kv, rv, e_s;
  logic        test_input_bit, s_oe, e_oe;
  logic [7:0]  strobe_out, seg_out, e_seg, e_str, d;
  logic [9:0]  rom_img [0:2047];
  logic [10:0] used [$];
  logic [30:0] snap [$];
  logic [1:0]  irqs [$];
  logic [3:0]  mpage;
  logic [6:0]  mpc;
  logic [30:0] s;
  integer      seed = 56877;
  integer      mismatches = 0;
  integer      comparisons = 0;
  integer      i, n;

  four_bit_controller_core i_four_bit_controller_core (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .rom_we(rom_we), .rom_waddr(rom_waddr),
    .rom_wdata(rom_wdata), .key_in(key_in), .test_input_bit(test_input_bit),
    .high_priority_irq(hpi), .low_priority_line(lpl), .s_in(s_in), .s_out(s_out),
    .s_oe(s_oe), .strobe_out(strobe_out), .seg_out(seg_out), .f_out(f_out));
  key_ram_partner i_key_ram_partner (
    .s_out(s_out), .s_oe(s_oe), .key_val(kv), .test_val(tv), .ram_nib(rv),
    .key_in(key_in), .test_input_bit(test_input_bit), .s_in(s_in));

  // ---------------------------------------------------------------
  // program builder and expectations
  // ---------------------------------------------------------------
  function automatic logic [6:0] next_pc(input logic [6:0] p);
    return {p[5:0], ~(p[6] ^ p[5])};
  endfunction
  task wr(input logic [10:0] a, input logic [9:0] w);
    rom_img[a] = w;
    used.push_back(a);
  endtask
  // put=0 marks a slot where no main-line word runs (interrupt, handler)
  task step(input logic [9:0] w, input logic put, input logic [1:0] irq);
    if (put) begin
      wr({mpage, mpc}, w);
      mpc = next_pc(mpc);
    end
    snap.push_back({e_f, e_str, e_seg, e_oe, e_s});
    irqs.push_back(irq);
  endtask
  task ins(input logic [9:0] w);
    step(w, 1'b1, 2'b00);
  endtask
  task oiu(input logic [7:0] v);
    e_seg = v;
    ins({2'b11, v});
  endtask
  task show(input logic [3:0] v);
    e_s  = v;
    e_oe = 1'b1;
    ins(10'h018);
  endtask
  task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    close_out;
  end

  initial begin
    sys_rst = 1'b1; ce = 1'b1; rom_we = 1'b0; rom_waddr = 11'h000; rom_wdata = 10'h000;
    hpi = 1'b0; lpl = 1'b0; tv = 1'b1;
    kv = $random(seed); rv = $random(seed);
    e_f = 10'h000; e_str = 8'h00; e_seg = 8'h00; e_oe = 1'b0; e_s = 4'h0;
    mpage = 4'h0; mpc = 7'h00;
    ins(10'h0B1);
    ins(10'h180);
    mpage = 4'h1; mpc = 7'h00;
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      oiu(d);
    end
    for (i = 0; i < 10; i++) begin
      e_f[i] = 1'b1;
      ins(10'h080 | 10'(i));
    end
    for (i = 0; i < 3; i++) begin
      n = {$random(seed)} % 10;
      e_f[n] = 1'b0;
      ins(10'h090 | 10'(n));
    end
    ins(10'h035); show(4'h5); ins(10'h000); show(4'hA); ins(10'h001); show(4'h6);
    ins(10'h014); ins(10'h015); ins(10'h014); e_str = 8'h05; ins(10'h016);
    ins(10'h107); ins(10'h0B3); e_str = 8'h37; ins(10'h017);
    ins(10'h00A); ins(10'h3AA); ins(10'h00B); ins(10'h399); oiu(8'h55);
    ins(10'h00B); oiu(8'h66);
    ins(10'h03F); ins(10'h002); ins(10'h311); show(4'h0);
    ins(10'h003); oiu(8'h22); show(4'hF); ins(10'h021); ins(10'h333); show(4'h0);
    ins(10'h007); ins(10'h034); ins(10'h025); show(4'h9);
    ins(10'h025); ins(10'h344); show(4'h4); ins(10'h00E);
    ins(10'h110); ins(10'h039); ins(10'h051); ins(10'h030);
    ins(10'h051); ins(10'h040); show(4'h9);
    ins(10'h01B); show(kv); e_oe = 1'b0; ins(10'h019); ins(10'h01A); show(rv);
    ins(10'h01D); ins(10'h377); oiu(8'h78);
    wr(11'h010, 10'h3C3); wr({4'h0, next_pc(7'h10)}, 10'h00C);
    wr(11'h020, 10'h35A); wr({4'h0, next_pc(7'h20)}, 10'h00C);
    ins(10'h010); ins(10'h012);
    step(10'h000, 1'b0, 2'b01); e_seg = 8'h5A; step(10'h000, 1'b0, 2'b00);
    step(10'h000, 1'b0, 2'b00);
    // a lone low request leaves the high line armed
    step(10'h000, 1'b0, 2'b10); e_seg = 8'hC3; step(10'h000, 1'b0, 2'b00);
    step(10'h000, 1'b0, 2'b00); oiu(8'h3C);
    ins(10'h010); ins(10'h012);
    step(10'h000, 1'b0, 2'b11); e_seg = 8'hC3; step(10'h000, 1'b0, 2'b01);
    step(10'h000, 1'b0, 2'b01); e_seg = 8'h3D; step(10'h33D, 1'b1, 2'b01);
    // ---------------------------------------------------------------
    // reset, program load, then one look per instruction slot
    // ---------------------------------------------------------------
    repeat (6) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    foreach (used[k]) begin
      rom_we    = 1'b1;
      rom_waddr = used[k];
      rom_wdata = rom_img[used[k]];
      @(negedge clk);
    end
    rom_we = 1'b0;
    {hpi, lpl} = irqs[0];
    // look mid-slot so the exec edge is far away either way
    repeat (1500 - used.size()) @(negedge clk);
    foreach (snap[k]) begin
      s = snap[k];
      chk("f_out", s[30:21], f_out);
      chk("strobe_out", {2'b00, s[20:13]}, {2'b00, strobe_out});
      chk("seg_out", {2'b00, s[12:5]}, {2'b00, seg_out});
      chk("s_oe", {9'h000, s[4]}, {9'h000, s_oe});
      if (s[4]) chk("s_out", {6'h00, s[3:0]}, {6'h00, s_out});
      // low enable holds off the due instruction
      if (k == 8) begin
        ce = 1'b0;
        repeat (1000) @(negedge clk);
        chk("f_out frozen", s[30:21], f_out);
        ce = 1'b1;
      end
      if (k + 1 < irqs.size()) {hpi, lpl} = irqs[k + 1];
      repeat (1000) @(negedge clk);
    end
    close_out;
  end
endmodule
`default_nettype wire
